// *** dbx_debug_executor.sv ***
`timescale 1ns/100ps
module dbx_debug_executor
  import dbx_pkg::*;
(
  // Core clock and control
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Serial link word port
  input wire logic link_clk_in,
  input wire logic link_word_strobe_in,
  input wire logic [15:0] link_word_in,
  output logic [16:0] link_resp_out,
  // Processor state
  input wire logic enter_debug_in,
  input wire logic [31:0] cur_instr_pc_in,
  input wire logic [31:0] fault_addr_in,
  output logic debug_state_out,
  output logic resume_out,
  output logic exception_out,
  output logic [31:0] exc_fault_addr_out,
  output logic [31:0] run_pc_out,
  output logic [15:0] run_status_out,
  // Memory access
  output dbx_mem_req_s mem_req_out,
  input wire dbx_mem_rsp_s mem_rsp_in
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: size_bytes = 32'h1;
      SZ_WORD: size_bytes = 32'h2;
      default: size_bytes = 32'h4;
    endcase
  endfunction : size_bytes

  function automatic logic [2:0] data_words(input logic [1:0] sz);
    data_words = (sz == SZ_LONG) ? 3'h2 : 3'h1;
  endfunction : data_words

  function automatic logic [31:0] fit(input logic [1:0] sz,
                                      input logic [31:0] v);
    unique case (sz)
      SZ_BYTE: fit = {24'h0, v[7:0]};
      SZ_WORD: fit = {16'h0, v[15:0]};
      default: fit = v;
    endcase
  endfunction : fit

  // ****************************************
  // Link domain
  // ****************************************
  logic lrst_s1_q, lrst_n_q, lce_s1_q, lce_q;
  logic [15:0] rx_word_q;
  logic rx_tog_q;
  logic tx_s1_q, tx_s2_q, tx_s3_q;
  logic rsp_tog_q;
  logic [16:0] resp_q, tx_word_q;

  always_ff @(posedge link_clk_in) begin
    lrst_s1_q <= reset_n_in;
    lrst_n_q <= lrst_s1_q;
    lce_s1_q <= ce_in;
    lce_q <= lce_s1_q;
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      rx_word_q <= 16'h0;
      rx_tog_q <= 1'b0;
    end else if (lce_q && link_word_strobe_in) begin
      rx_word_q <= link_word_in;
      rx_tog_q <= ~rx_tog_q;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n_q) begin
      tx_s1_q <= 1'b0;
      tx_s2_q <= 1'b0;
      tx_s3_q <= 1'b0;
      link_resp_out <= RESP_NOTRDY;
    end else if (lce_q) begin
      tx_s1_q <= rsp_tog_q;
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
      if (tx_s2_q ^ tx_s3_q) begin
        link_resp_out <= tx_word_q;
      end
    end
  end

  // ****************************************
  // Core side word event
  // ****************************************
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  logic step, word_ev, mem_done, op_last, data_ph;
  logic [15:0] w;
  logic [31:0] opnd_full, data_full;
  dbx_state_e state_q;
  dbx_cmd_e cmd_q, dec_cmd, start_cmd;
  logic [1:0] size_q, start_size;
  logic [2:0] cnt_q;
  logic [31:0] addr_q, data_q, pc_q;
  logic [15:0] res_lo_q;
  logic debug_q;
  dbx_mem_req_s mem_req_q;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
    end else if (ce_in) begin
      rx_s1_q <= rx_tog_q;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  assign step = ce_in;
  assign w = rx_word_q;
  assign word_ev = step && (rx_s2_q ^ rx_s3_q);
  assign mem_done = step && mem_req_q.req && mem_rsp_in.done;
  assign op_last = word_ev && state_q == ST_OPND && cnt_q == 3'h1;
  // Most significant word arrives first
  assign opnd_full = {addr_q[15:0], w};
  assign data_full = {data_q[15:0], w};
  assign data_ph = (cmd_q == CMD_WRITE || cmd_q == CMD_FILL) &&
                   cnt_q <= data_words(size_q);

  // ****************************************
  // Command decode
  // ****************************************
  always_comb begin
    dec_cmd = CMD_BAD;
    if (w == OPC_NOP) begin
      dec_cmd = CMD_NOP;
    end else if (w[15:4] == OPC_READ_SYSTEM_REGISTER_CMD) begin
      dec_cmd = CMD_READ_SYSTEM_REGISTER_CMD;
    end else if (w[15:4] == OPC_WRITE_SYSTEM_REGISTER_CMD) begin
      dec_cmd = CMD_WRITE_SYSTEM_REGISTER_CMD;
    end else if (w == OPC_GO) begin
      dec_cmd = CMD_GO;
    end else if (w == OPC_CALL) begin
      dec_cmd = CMD_CALL;
    end else if (w[7:6] != SZ_BAD && w[5:0] == 6'h0) begin
      unique case (w[15:8])
        OPC_READ: dec_cmd = CMD_READ;
        OPC_WRITE: dec_cmd = CMD_WRITE;
        OPC_DUMP: dec_cmd = CMD_DUMP;
        OPC_FILL: dec_cmd = CMD_FILL;
        default: dec_cmd = CMD_BAD;
      endcase
    end
  end

  // ****************************************
  // System registers
  // ****************************************
  logic [31:0] ret_q, tmpa_q, vbr_q, usp_q, ssp_q, sreg_rd, cur_sp;
  logic [15:0] stat_q;
  logic [2:0] src_q, dst_q;
  logic sreg_we, ptr_we, sp_we;
  logic [31:0] ptr_wdata;

  assign cur_sp = stat_q[SR_SUPER_BIT] ? ssp_q : usp_q;
  assign sreg_we = step && op_last && cmd_q == CMD_WRITE_SYSTEM_REGISTER_CMD;
  assign ptr_we = mem_done && state_q == ST_MEM && !mem_rsp_in.err &&
                  cmd_q != CMD_CALL;
  assign ptr_wdata = mem_req_q.addr + size_bytes(mem_req_q.size);
  assign sp_we = mem_done && state_q == ST_MEM && !mem_rsp_in.err &&
                 cmd_q == CMD_CALL;

  always_comb begin
    unique case (w[3:0])
      SEL_RET: sreg_rd = ret_q;
      SEL_CUR: sreg_rd = cur_instr_pc_in;
      SEL_TMPA: sreg_rd = tmpa_q;
      SEL_FAULT: sreg_rd = fault_addr_in;
      SEL_VBR: sreg_rd = vbr_q;
      SEL_STAT: sreg_rd = {16'h0, stat_q};
      SEL_USP: sreg_rd = usp_q;
      SEL_SSP: sreg_rd = ssp_q;
      SEL_SRC: sreg_rd = {29'h0, src_q};
      SEL_DST: sreg_rd = {29'h0, dst_q};
      default: sreg_rd = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ret_q <= 32'h0;
      tmpa_q <= 32'h0;
      vbr_q <= 32'h0;
      stat_q <= STAT_RST;
      usp_q <= 32'h0;
      ssp_q <= 32'h0;
      src_q <= 3'h0;
      dst_q <= 3'h0;
    end else if (step) begin
      if (ptr_we) begin
        tmpa_q <= ptr_wdata;
      end
      if (sp_we && stat_q[SR_SUPER_BIT]) begin
        ssp_q <= mem_req_q.addr;
      end else if (sp_we) begin
        usp_q <= mem_req_q.addr;
      end
      if (sreg_we) begin
        unique case (res_lo_q[3:0])
          SEL_RET: ret_q <= opnd_full;
          SEL_TMPA: tmpa_q <= opnd_full;
          SEL_VBR: vbr_q <= opnd_full;
          SEL_STAT: stat_q <= opnd_full[15:0];
          SEL_USP: usp_q <= opnd_full;
          SEL_SSP: ssp_q <= opnd_full;
          SEL_SRC: src_q <= opnd_full[2:0];
          SEL_DST: dst_q <= opnd_full[2:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_NOP;
      size_q <= SZ_BYTE;
      cnt_q <= 3'h0;
      addr_q <= 32'h0;
      data_q <= 32'h0;
      res_lo_q <= 16'h0;
      pc_q <= 32'h0;
    end else if (step) begin
      unique case (state_q)
        ST_IDLE: if (word_ev && debug_q) begin
          cmd_q <= dec_cmd;
          size_q <= w[7:6];
          res_lo_q <= {12'h0, w[3:0]};
          unique case (dec_cmd)
            CMD_WRITE_SYSTEM_REGISTER_CMD, CMD_READ, CMD_CALL: begin
              cnt_q <= 3'h2;
              state_q <= ST_OPND;
            end
            CMD_WRITE: begin
              cnt_q <= 3'h2 + data_words(w[7:6]);
              state_q <= ST_OPND;
            end
            CMD_FILL: begin
              cnt_q <= data_words(w[7:6]);
              addr_q <= tmpa_q;
              state_q <= ST_OPND;
            end
            CMD_DUMP: begin
              addr_q <= tmpa_q;
              state_q <= ST_MEM;
            end
            CMD_READ_SYSTEM_REGISTER_CMD: begin
              res_lo_q <= sreg_rd[15:0];
              state_q <= ST_RES_LO;
            end
            CMD_GO: begin
              pc_q <= ret_q;
              state_q <= ST_FETCH;
            end
            default: ;
          endcase
        end
        ST_OPND: if (word_ev) begin
          cnt_q <= cnt_q - 3'h1;
          if (data_ph) begin
            data_q <= data_full;
          end else begin
            addr_q <= opnd_full;
          end
          if (cnt_q == 3'h1 && cmd_q == CMD_CALL) begin
            pc_q <= opnd_full;
          end
          if (cnt_q == 3'h1) begin
            state_q <= (cmd_q == CMD_WRITE_SYSTEM_REGISTER_CMD) ? ST_IDLE : ST_MEM;
          end
        end
        ST_MEM: if (mem_done) begin
          if (cmd_q == CMD_CALL && !mem_rsp_in.err) begin
            state_q <= ST_FETCH;
          end else if (cmd_q != CMD_CALL && !mem_req_q.write &&
                       !mem_rsp_in.err && size_q == SZ_LONG) begin
            res_lo_q <= mem_rsp_in.rdata[15:0];
            state_q <= ST_RES_LO;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_RES_LO: if (word_ev) begin
          state_q <= ST_IDLE;
        end
        ST_FETCH: if (mem_done) begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Memory requests
  // ****************************************
  logic mem_start, fetch_start;
  logic [31:0] start_addr, fetch_pc;

  assign start_cmd = (state_q == ST_IDLE) ? dec_cmd : cmd_q;
  assign start_size = (state_q == ST_IDLE) ? w[7:6] : size_q;
  assign mem_start = (word_ev && debug_q && state_q == ST_IDLE &&
                      dec_cmd == CMD_DUMP) ||
                     (op_last && cmd_q != CMD_WRITE_SYSTEM_REGISTER_CMD);
  assign fetch_start = (word_ev && debug_q && state_q == ST_IDLE &&
                        dec_cmd == CMD_GO) || sp_we;
  assign fetch_pc = (state_q == ST_IDLE) ? ret_q : pc_q;

  always_comb begin
    unique case (start_cmd)
      CMD_DUMP: start_addr = tmpa_q;
      CMD_READ: start_addr = opnd_full;
      CMD_CALL: start_addr = cur_sp - PUSH_BYTES;
      default: start_addr = addr_q;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      mem_req_q <= '0;
    end else if (step) begin
      if (mem_done) begin
        mem_req_q.req <= 1'b0;
      end
      if (mem_start) begin
        mem_req_q.req <= 1'b1;
        mem_req_q.fetch <= 1'b0;
        mem_req_q.addr <= start_addr;
        mem_req_q.write <= start_cmd == CMD_WRITE ||
                           start_cmd == CMD_FILL || start_cmd == CMD_CALL;
        if (start_cmd == CMD_CALL) begin
          mem_req_q.size <= SZ_LONG;
          mem_req_q.space <= SPACE_SUP_DATA;
          mem_req_q.wdata <= ret_q;
        end else begin
          mem_req_q.size <= start_size;
          mem_req_q.space <= (start_cmd == CMD_READ ||
                              start_cmd == CMD_DUMP) ? src_q : dst_q;
          mem_req_q.wdata <= fit(start_size, data_full);
        end
      end
      if (fetch_start) begin
        mem_req_q.req <= 1'b1;
        mem_req_q.fetch <= 1'b1;
        mem_req_q.write <= 1'b0;
        mem_req_q.size <= SZ_WORD;
        mem_req_q.addr <= fetch_pc;
        mem_req_q.space <= stat_q[SR_SUPER_BIT] ? SPACE_SUP_PROG :
                           SPACE_USR_PROG;
      end
    end
  end

  assign mem_req_out = mem_req_q;

  // ****************************************
  // Responses
  // ****************************************
  logic resp_set;
  logic [16:0] resp_val, rd_resp;

  always_comb begin
    unique case (size_q)
      SZ_BYTE: rd_resp = {9'h0, mem_rsp_in.rdata[7:0]};
      SZ_WORD: rd_resp = {1'b0, mem_rsp_in.rdata[15:0]};
      default: rd_resp = {1'b0, mem_rsp_in.rdata[31:16]};
    endcase
  end

  always_comb begin
    resp_set = 1'b0;
    resp_val = RESP_NOTRDY;
    if (mem_done && state_q == ST_MEM) begin
      resp_set = !(cmd_q == CMD_CALL && !mem_rsp_in.err);
      if (mem_rsp_in.err) begin
        resp_val = RESP_ERROR;
      end else if (mem_req_q.write) begin
        resp_val = RESP_DONE;
      end else begin
        resp_val = rd_resp;
      end
    end else if (word_ev) begin
      resp_set = 1'b1;
      unique case (state_q)
        ST_IDLE: begin
          resp_set = debug_q && dec_cmd != CMD_GO;
          if (dec_cmd == CMD_NOP) begin
            resp_val = RESP_DONE;
          end else if (dec_cmd == CMD_BAD) begin
            resp_val = RESP_ILLEGAL;
          end else if (dec_cmd == CMD_READ_SYSTEM_REGISTER_CMD) begin
            resp_val = {1'b0, sreg_rd[31:16]};
          end
        end
        ST_OPND: if (op_last && cmd_q == CMD_WRITE_SYSTEM_REGISTER_CMD) begin
          resp_val = RESP_DONE;
        end
        ST_RES_LO: resp_val = {1'b0, res_lo_q};
        default: resp_val = RESP_NOTRDY;
      endcase
    end
  end

  // Latest response, handed to the link one at a time
  logic ack_s1_q, ack_s2_q, pend_q, tx_busy;
  assign tx_busy = rsp_tog_q ^ ack_s2_q;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      resp_q <= RESP_NOTRDY;
      tx_word_q <= RESP_NOTRDY;
      rsp_tog_q <= 1'b0;
      pend_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else if (step) begin
      ack_s1_q <= tx_s3_q;
      ack_s2_q <= ack_s1_q;
      if (resp_set) begin
        resp_q <= resp_val;
        pend_q <= 1'b1;
      end else if (pend_q && !tx_busy) begin
        tx_word_q <= resp_q;
        rsp_tog_q <= ~rsp_tog_q;
        pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Debug state and exit
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      debug_q <= 1'b0;
      resume_out <= 1'b0;
      exception_out <= 1'b0;
      exc_fault_addr_out <= 32'h0;
    end else if (step) begin
      resume_out <= 1'b0;
      exception_out <= 1'b0;
      if (mem_done && state_q == ST_FETCH) begin
        debug_q <= 1'b0;
        resume_out <= !mem_rsp_in.err;
        exception_out <= mem_rsp_in.err;
        if (mem_rsp_in.err) begin
          exc_fault_addr_out <= mem_req_q.addr;
        end
      end else if (enter_debug_in) begin
        debug_q <= 1'b1;
      end
    end
  end

  assign debug_state_out = debug_q;
  assign run_pc_out = pc_q;
  assign run_status_out = stat_q;

  // ****************************************
  // Checks
  // ****************************************
  logic rd_fin, wr_fin;
  logic [31:0] req_addr;
  assign rd_fin = mem_done && state_q == ST_MEM && !mem_req_q.write;
  assign wr_fin = mem_done && state_q == ST_MEM && mem_req_q.write &&
                  cmd_q != CMD_CALL;
  assign req_addr = mem_req_q.addr;

  property p_write_system_register_cmd_done;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sreg_we |=> resp_q == RESP_DONE && pend_q;
  endproperty
  a_write_system_register_cmd_done: assert property (p_write_system_register_cmd_done)
    else $error("write register did not answer complete");

  property p_fault_ro;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sreg_we && res_lo_q[3:0] == SEL_FAULT |=>
        $stable(vbr_q) && $stable(stat_q) && $stable(ret_q);
  endproperty
  a_fault_ro: assert property (p_fault_ro)
    else $error("fault address write changed a register");

  property p_rd_err;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      rd_fin && mem_rsp_in.err |=> resp_q == RESP_ERROR;
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("read error status wrong");

  property p_wr_stat;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      wr_fin |=> resp_q == ($past(mem_rsp_in.err) ? RESP_ERROR : RESP_DONE);
  endproperty
  a_wr_stat: assert property (p_wr_stat)
    else $error("write status wrong");

  property p_ptr_adv;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      ptr_we && mem_req_q.size == SZ_LONG |=>
        tmpa_q == $past(req_addr) + 32'h4;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv)
    else $error("long pointer did not advance by four");

  property p_busy;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      word_ev && state_q == ST_MEM && !mem_done |=> resp_q == RESP_NOTRDY;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy transfer not answered not ready");

  property p_byte_zero;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      rd_fin && !mem_rsp_in.err && size_q == SZ_BYTE |=>
        resp_q[16:8] == 9'h0;
  endproperty
  a_byte_zero: assert property (p_byte_zero)
    else $error("byte result not zero extended");

  property p_long_order;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      rd_fin && !mem_rsp_in.err && size_q == SZ_LONG |=>
        state_q == ST_RES_LO && res_lo_q == $past(mem_rsp_in.rdata[15:0]);
  endproperty
  a_long_order: assert property (p_long_order)
    else $error("long result low word not held");

  property p_illegal;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      word_ev && debug_q && state_q == ST_IDLE && dec_cmd == CMD_BAD |=>
        resp_q == RESP_ILLEGAL && state_q == ST_IDLE;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal command not answered");

  property p_call_err;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      mem_done && state_q == ST_MEM && cmd_q == CMD_CALL &&
        mem_rsp_in.err |=> debug_q && resp_q == RESP_ERROR;
  endproperty
  a_call_err: assert property (p_call_err)
    else $error("call stacking error mishandled");

  property p_fetch_fault;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      mem_done && state_q == ST_FETCH && mem_rsp_in.err |=>
        exception_out && !debug_q && exc_fault_addr_out == $past(req_addr);
  endproperty
  a_fetch_fault: assert property (p_fetch_fault)
    else $error("prefetch fault not raised");
endmodule : dbx_debug_executor

// *** dbx_mem_model.sv ***
`timescale 1ns/100ps
module dbx_mem_model
  import dbx_pkg::*;
(
  // Core clock
  input wire logic sys_clk_in,
  // Memory access
  input wire dbx_mem_req_s mem_req_in,
  output dbx_mem_rsp_s mem_rsp_out,
  output dbx_mem_req_s last_req_out
);
  // ****
  // Answers fast and slow in turn; top nibble f faults
  // ****
  logic [2:0] wait_q = '0;
  logic slow_q = 1'b0;
  logic [31:0] a;
  assign a = mem_req_in.addr;
  initial mem_rsp_out = '0;
  initial last_req_out = '0;
  always @(posedge sys_clk_in) begin
    mem_rsp_out <= '0;
    if (mem_req_in.req && !mem_rsp_out.done) begin
      wait_q <= wait_q + 3'h1;
      if (wait_q == (slow_q ? 3'h5 : 3'h0)) begin
        wait_q <= 3'h0;
        slow_q <= !slow_q;
        last_req_out <= mem_req_in;
        mem_rsp_out.done <= 1'b1;
        mem_rsp_out.err <= (a[31:28] == 4'hf);
        mem_rsp_out.rdata <= {~a[15:0], a[15:0]} &
          (mem_req_in.size == SZ_BYTE ? 32'hff :
          mem_req_in.size == SZ_WORD ? 32'hffff : 32'hffff_ffff);
      end
    end
  end
endmodule : dbx_mem_model

// *** dbx_pkg.sv ***
// What this block does
// - Select codes pick the ten system registers
// - Write operand is long; narrow targets take low
// - Write register answers command complete next
// - Fault address register ignores all writes
// - Write command selects register in bits 3..0
// - Read takes long address, source space code
// - Byte result zero-extended; word 16, long 32
// - Read ok clears bit 16; error gives 10001
// - Write takes address then sized data, destination space
// - Write ok gives 0ffff; error gives 10001
// - Read or dump advances kept address by size
// - Write or fill advances kept address by size
// - No-operation leaves the kept address alone
// - Size field decoded afresh on every command
// - Size in bits 7..6, bits 5..0 zero
// - Resume refetches from return counter, no result
// - First prefetch fault leaves debug, takes exception
// - Call pushes return counter, jumps to operand
// - Call stacking error reports error, stays debug
// - Transfers during memory access answer not ready
// - Long values move most significant word first
// - Unassigned opcodes do nothing, answer illegal
package dbx_pkg;
  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [3:0] SEL_RET = 4'h0;
  localparam logic [3:0] SEL_CUR = 4'h1;
  localparam logic [3:0] SEL_TMPA = 4'h8;
  localparam logic [3:0] SEL_FAULT = 4'h9;
  localparam logic [3:0] SEL_VBR = 4'ha;
  localparam logic [3:0] SEL_STAT = 4'hb;
  localparam logic [3:0] SEL_USP = 4'hc;
  localparam logic [3:0] SEL_SSP = 4'hd;
  localparam logic [3:0] SEL_SRC = 4'he;
  localparam logic [3:0] SEL_DST = 4'hf;
  // ****************************************
  // Command words and fields
  // ****************************************
  localparam logic [11:0] OPC_READ_SYSTEM_REGISTER_CMD = 12'h258;
  localparam logic [11:0] OPC_WRITE_SYSTEM_REGISTER_CMD = 12'h248;
  localparam logic [7:0] OPC_READ = 8'h19;
  localparam logic [7:0] OPC_WRITE = 8'h18;
  localparam logic [7:0] OPC_DUMP = 8'h1d;
  localparam logic [7:0] OPC_FILL = 8'h1c;
  localparam logic [15:0] OPC_GO = 16'h0c00;
  localparam logic [15:0] OPC_CALL = 16'h0800;
  localparam logic [15:0] OPC_NOP = 16'h0000;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;
  // ****************************************
  // Responses, spaces, reset values
  // ****************************************
  localparam logic [16:0] RESP_DONE = 17'h0ffff;
  localparam logic [16:0] RESP_NOTRDY = 17'h10000;
  localparam logic [16:0] RESP_ILLEGAL = 17'h1ffff;
  localparam logic [16:0] RESP_ERROR = 17'h10001;
  localparam int SR_SUPER_BIT = 13;
  localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUP_PROG = 3'h6;
  localparam logic [2:0] SPACE_USR_PROG = 3'h2;
  localparam logic [15:0] STAT_RST = 16'h2700;
  localparam logic [31:0] PUSH_BYTES = 32'h4;

  typedef struct packed {
    logic req;
    logic write;
    logic fetch;
    logic [1:0] size;
    logic [2:0] space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dbx_mem_req_s;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } dbx_mem_rsp_s;

  typedef enum {ST_IDLE, ST_OPND, ST_MEM, ST_RES_LO, ST_FETCH} dbx_state_e;
  typedef enum {CMD_NOP, CMD_BAD, CMD_READ_SYSTEM_REGISTER_CMD, CMD_WRITE_SYSTEM_REGISTER_CMD, CMD_READ,
    CMD_WRITE, CMD_DUMP, CMD_FILL, CMD_GO, CMD_CALL} dbx_cmd_e;
endpackage : dbx_pkg

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top import dbx_pkg::*; ;
  // ****
  // Bench signals
  // ****
  logic sys_clk_in = 0, link_clk_in = 0, reset_n_in = 0;
  logic stb = 0, dbg_req = 0, dbg, resume, exc, res_seen = 0, exc_seen = 0;
  logic [15:0] word = '0;
  logic [16:0] resp;
  logic [31:0] exc_pc, run_pc;
  logic [15:0] stat;
  dbx_mem_req_s req, last;
  dbx_mem_rsp_s rsp;
  int fails = 0, samples_checked = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  initial #3 forever #62.5 link_clk_in = ~link_clk_in;
  always @(posedge sys_clk_in) begin
    res_seen <= res_seen | resume;
    exc_seen <= exc_seen | exc;
  end
  dbx_debug_executor dbx_debug_executor_inst (.sys_clk_in, .reset_n_in,
    .ce_in(1'b1), .link_clk_in, .link_word_strobe_in(stb),
    .link_word_in(word), .link_resp_out(resp), .enter_debug_in(dbg_req),
    .cur_instr_pc_in(32'h0), .fault_addr_in(32'hc0de_1230),
    .debug_state_out(dbg), .resume_out(resume), .exception_out(exc),
    .exc_fault_addr_out(exc_pc), .run_pc_out(run_pc),
    .run_status_out(stat), .mem_req_out(req), .mem_rsp_in(rsp));
  dbx_mem_model dbx_mem_model_inst (.sys_clk_in, .mem_req_in(req),
    .mem_rsp_out(rsp), .last_req_out(last));
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED %0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : check
  task automatic send(input logic [15:0] w);
    @(negedge link_clk_in) {stb, word} = {1'b1, w};
    @(negedge link_clk_in) stb = 1'b0;
    repeat (14) @(negedge link_clk_in);
  endtask : send
  task automatic send_l(input logic [31:0] v);
    send(v[31:16]);
    send(v[15:0]);
  endtask : send_l
  task automatic write_system_register_cmd(input logic [3:0] sel, input logic [31:0] v);
    send({OPC_WRITE_SYSTEM_REGISTER_CMD, sel});
    send_l(v);
  endtask : write_system_register_cmd
  task automatic enter;
    @(negedge sys_clk_in) dbg_req = 1'b1;
    @(negedge sys_clk_in) dbg_req = 1'b0;
    repeat (4) @(negedge link_clk_in);
  endtask : enter
  task automatic finish_test;
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ****
  // Scenarios
  // ****
  task automatic t_sreg;
    write_system_register_cmd(SEL_SRC, 32'h1234_0005);
    check(resp, RESP_DONE);
    send({OPC_READ_SYSTEM_REGISTER_CMD, SEL_SRC});
    check(resp, 32'h0);
    send(OPC_NOP);
    check(resp, 32'h5);
    write_system_register_cmd(SEL_FAULT, 32'h0bad_0bad);
    send({OPC_READ_SYSTEM_REGISTER_CMD, SEL_FAULT});
    check(resp, 32'hc0de);
    send(OPC_NOP);
    check(resp, 32'h1230);
    write_system_register_cmd(SEL_STAT, 32'hffff_2704);
    check(stat, 32'h2704);
  endtask : t_sreg
  task automatic t_read;
    send({OPC_READ, SZ_LONG, 6'h0});
    send_l(32'h0000_1000);
    check({last.space, last.size}, {3'h5, SZ_LONG});
    check(resp, 32'hefff);
    send(OPC_NOP);
    check(resp, 32'h1000);
    send({OPC_DUMP, SZ_BYTE, 6'h0});
    check(resp, 32'h04);
    send(OPC_NOP);
    send({OPC_DUMP, SZ_WORD, 6'h0});
    check(last.addr, 32'h1005);
    check(resp, 32'h1005);
    send({OPC_READ, SZ_WORD, 6'h0});
    send_l(32'hf000_0000);
    check(resp, RESP_ERROR);
  endtask : t_read
  task automatic t_write;
    write_system_register_cmd(SEL_DST, 32'h1);
    send({OPC_WRITE, SZ_WORD, 6'h0});
    send_l(32'h0000_2000);
    send(16'hbeef);
    check(last.wdata, 32'hbeef);
    check(last.space, 32'h1);
    check(resp, RESP_DONE);
    send({OPC_FILL, SZ_LONG, 6'h0});
    send_l(32'hcafe_f00d);
    check(last.addr, 32'h2002);
    check(last.wdata, 32'hcafe_f00d);
    send({OPC_WRITE, SZ_BYTE, 6'h0});
    send_l(32'hf000_0010);
    send(16'h00aa);
    check(resp, RESP_ERROR);
  endtask : t_write
  task automatic t_bad;
    send(16'h1bc0);
    check(resp, RESP_ILLEGAL);
    send(16'h7777);
    check(resp, RESP_ILLEGAL);
  endtask : t_bad
  task automatic t_go;
    write_system_register_cmd(SEL_RET, 32'h0000_4000);
    send(OPC_GO);
    check(res_seen, 1'b1);
    check(run_pc, 32'h4000);
    check(last.fetch, 1'b1);
    enter;
    write_system_register_cmd(SEL_RET, 32'hf000_0001);
    send(OPC_GO);
    check(exc_seen, 1'b1);
    check(exc_pc, 32'hf000_0001);
    check(dbg, 1'b0);
  endtask : t_go
  task automatic t_call;
    enter;
    send(OPC_CALL);
    send_l(32'h0000_5000);
    check(resp, RESP_ERROR);
    check(dbg, 1'b1);
    write_system_register_cmd(SEL_SSP, 32'h0000_3000);
    write_system_register_cmd(SEL_RET, 32'h0000_4444);
    send(OPC_CALL);
    send_l(32'h0000_5000);
    check(run_pc, 32'h5000);
    check(last.addr, 32'h5000);
    check(dbg, 1'b0);
    enter;
    send({OPC_READ_SYSTEM_REGISTER_CMD, SEL_SSP});
    check(resp, 32'h0);
    send(OPC_NOP);
    check(resp, 32'h2ffc);
  endtask : t_call
  initial begin
    repeat (5) @(negedge link_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge link_clk_in);
    enter;
    t_sreg;
    t_read;
    t_write;
    t_bad;
    t_go;
    t_call;
    finish_test;
  end
  initial begin
    #300000;
    fails++;
    finish_test;
  end
endmodule : tb_top
